// [common/batt_cfg_pkg.sv]
// constants, types and lookup functions of the battery configuration register bank
package batt_cfg_pkg;

  // two-wire target addresses
  localparam logic [6:0] CMD_ADDR    = 7'h6B;
  localparam logic [6:0] MIRROR_ADDR = 7'h69;

  // register offsets
  localparam logic [7:0] OFF_CHEM      = 8'h07;
  localparam logic [7:0] OFF_CHG_CTRL  = 8'h1D;
  localparam logic [7:0] OFF_LOW_THR   = 8'h1E;
  localparam logic [7:0] OFF_PMODE     = 8'h00;
  localparam logic [7:0] OFF_CHG_STATE = 8'h20;

  // register values
  localparam logic [7:0] PMODE_CABLE  = 8'h01;
  localparam logic [7:0] PMODE_BATT   = 8'h02;
  localparam logic [7:0] CHG_OFF      = 8'h00;
  localparam logic [7:0] CHG_ON       = 8'h01;
  localparam logic [7:0] CTRL_DISABLE = 8'h00;
  localparam logic [7:0] CTRL_AUTO    = 8'h01;
  localparam logic [7:0] LOW_CODE_MAX = 8'h08;
  localparam logic [7:0] READ_ZERO    = 8'h00;
  localparam logic       CTRL_RESET   = 1'b1;

  // voltages in millivolts
  localparam int         MV_W           = 13;
  localparam logic [12:0] WARN_MARGIN_MV = 13'h003C;
  localparam logic [12:0] FULL_MV_STD    = 13'h1068;
  localparam logic [12:0] FULL_MV_LFP    = 13'h0E10;

  // timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int unsigned WARN_HOLD_MS   = 5000;
  localparam int unsigned BEEP_PERIOD_MS = 1000;
  localparam int unsigned BEEP_ON_MS     = 50;
  localparam int unsigned WARN_HOLD_CYC  = WARN_HOLD_MS * CYC_PER_MS;
  localparam int unsigned BEEP_PER_CYC   = BEEP_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned BEEP_ON_CYC    = BEEP_ON_MS * CYC_PER_MS;

  typedef enum logic [2:0] {
    CHEM_LIPO    = 3'b000,
    CHEM_LIFEPO4 = 3'b001,
    CHEM_LIION   = 3'b010,
    CHEM_NIMH    = 3'b011,
    CHEM_LEAD    = 3'b100
  } chem_t;
  localparam chem_t CHEM_RESET = CHEM_LIPO;
  localparam int    CHEM_N     = 5;

  // code stored for a chemistry, per board variant
  function automatic logic [7:0] chem_code(chem_t c, logic ext);
    logic [7:0] r;
    r = 8'h00;
    case (c)
      CHEM_LIPO:    r = ext ? 8'h50 : 8'h53;
      CHEM_LIFEPO4: r = ext ? 8'h51 : 8'h46;
      CHEM_LIION:   r = ext ? 8'h4F : 8'h49;
      CHEM_NIMH:    r = ext ? 8'h4D : 8'h48;
      CHEM_LEAD:    r = ext ? 8'h41 : 8'h4C;
      default:      r = 8'h00;
    endcase
    return r;
  endfunction

  // returns {valid, chemistry}
  function automatic logic [3:0] chem_lookup(logic [7:0] code, logic ext);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < CHEM_N; i++) begin
      if (code == chem_code(chem_t'(3'(i)), ext)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] chem_low_code(chem_t c);
    logic [3:0] r;
    case (c)
      CHEM_LIFEPO4: r = 4'h1;
      CHEM_LIION:   r = 4'h6;
      CHEM_NIMH:    r = 4'h4;
      CHEM_LEAD:    r = 4'h3;
      default:      r = 4'h7;
    endcase
    return r;
  endfunction

  function automatic logic [12:0] chem_full_mv(chem_t c);
    return (c == CHEM_LIFEPO4) ? FULL_MV_LFP : FULL_MV_STD;
  endfunction

  function automatic logic [12:0] low_code_mv(logic [3:0] code);
    logic [12:0] r;
    case (code)
      4'h0:    r = 13'h0B54;
      4'h1:    r = 13'h0B86;
      4'h2:    r = 13'h0BB8;
      4'h3:    r = 13'h0C1C;
      4'h4:    r = 13'h0C80;
      4'h5:    r = 13'h0CE4;
      4'h6:    r = 13'h0D48;
      4'h7:    r = 13'h0DAC;
      default: r = 13'h0E10;
    endcase
    return r;
  endfunction

endpackage

// [hdl/charger_auto.sv]
// automatic charger switching and charge current lamp
`timescale 1ns/1ps
module charger_auto
  import batt_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // control
  input  wire logic                        ctrl_auto,
  input  wire logic                        cable_powered,
  input  wire logic [batt_cfg_pkg::MV_W-1:0] batt_mv,
  input  wire logic [batt_cfg_pkg::MV_W-1:0] full_mv,
  input  wire logic                        current_flowing,
  // status
  output logic                             charger_on,
  output logic                             charge_current_lamp
);
  typedef struct packed {
    logic on;
    logic lamp;
  } chg_state_t;

  chg_state_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    // enabled only means charging is allowed, not that it flows
    s_d.on   = ctrl_auto && cable_powered && (batt_mv < full_mv);
    s_d.lamp = s_q.on && current_flowing;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign charger_on          = s_q.on;
  assign charge_current_lamp = s_q.lamp;
endmodule

// [hdl/battery_warn.sv]
// low battery lamp, beeper and delayed shutdown request
`timescale 1ns/1ps
module battery_warn
  import batt_cfg_pkg::*;
#(
  parameter int unsigned HOLD_CYC     = batt_cfg_pkg::WARN_HOLD_CYC,
  parameter int unsigned BEEP_PER_CYC = batt_cfg_pkg::BEEP_PER_CYC,
  parameter int unsigned BEEP_ON_CYC  = batt_cfg_pkg::BEEP_ON_CYC
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // levels
  input  wire logic [batt_cfg_pkg::MV_W-1:0] batt_mv,
  input  wire logic [batt_cfg_pkg::MV_W-1:0] low_mv,
  // indications
  output logic                               warn_lamp,
  output logic                               beeper,
  output logic                               shutdown_req
);
  typedef struct packed {
    logic        warn;
    logic        beep;
    logic        shut;
    logic [31:0] hold;
    logic [31:0] tone;
  } warn_state_t;

  warn_state_t s_q, s_d;
  logic [MV_W:0] warn_level;

  always_comb begin
    warn_level = {1'b0, low_mv} + {1'b0, WARN_MARGIN_MV};
    s_d        = s_q;
    s_d.warn   = {1'b0, batt_mv} < warn_level;
    if (!s_q.warn) begin
      s_d.hold = '0;
      s_d.tone = '0;
      s_d.beep = 1'b0;
      s_d.shut = 1'b0;
    end else begin
      if (s_q.hold < HOLD_CYC) begin
        s_d.hold = s_q.hold + 32'h0000_0001;
      end else begin
        s_d.shut = 1'b1;
      end
      s_d.tone = (s_q.tone >= BEEP_PER_CYC - 1) ? '0 : s_q.tone + 32'h0000_0001;
      s_d.beep = s_q.tone < BEEP_ON_CYC;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign warn_lamp    = s_q.warn;
  assign beeper       = s_q.beep;
  assign shutdown_req = s_q.shut;
endmodule

// [hdl/battery_charge_config_regs.sv]
// battery configuration register bank behind a two-wire target port
`timescale 1ns/1ps
module battery_charge_config_regs
  import batt_cfg_pkg::*;
#(
  parameter int unsigned WARN_HOLD_CYCLES  = batt_cfg_pkg::WARN_HOLD_CYC,
  parameter int unsigned BEEP_PERIOD_CYCLES = batt_cfg_pkg::BEEP_PER_CYC,
  parameter int unsigned BEEP_ON_CYCLES    = batt_cfg_pkg::BEEP_ON_CYC
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // two-wire bus, open drain data
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe,
  // board and power status
  input  wire logic                          board_ext,
  input  wire logic                          cable_powered,
  input  wire logic                          fw_update,
  input  wire logic [batt_cfg_pkg::MV_W-1:0] batt_mv,
  input  wire logic                          current_flowing,
  // charger
  output logic                               charger_on,
  output logic                               charge_current_lamp,
  // low battery indication
  output logic                               warn_lamp,
  output logic                               beeper,
  output logic                               shutdown_req
);

  ////////////////////////////////////////////////////////////////////////////
  // types

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_RX   = 3'b001,
    I_ACK  = 3'b010,
    I_TX   = 3'b011,
    I_RACK = 3'b100
  } link_st_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_OFFS = 2'b01,
    K_DATA = 2'b10
  } byte_kind_t;

  typedef struct packed {
    link_st_t   st;
    byte_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rd;
    logic       mirror;
    logic [7:0] offs;
    logic       scl_p;
    logic       sda_p;
    logic       sda_out;
    logic       sda_en;
    chem_t      chem;
    logic       ext;
    logic       strap_done;
    logic [3:0] low_code;
    logic       ctrl_auto;
  } regs_state_t;

  regs_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic [7:0]        rdata;
  logic              wr_fire;
  logic [3:0]        lookup;
  logic [MV_W-1:0]   low_mv;
  logic [MV_W-1:0]   full_mv;
  logic              chg_on_int;

  assign scl_rise   = scl_i & ~s_q.scl_p;
  assign scl_fall   = ~scl_i & s_q.scl_p;
  // data may only move while the clock is low, so these are framing
  assign start_cond = s_q.scl_p & scl_i & s_q.sda_p & ~sda_i;
  assign stop_cond  = s_q.scl_p & scl_i & ~s_q.sda_p & sda_i;

  assign low_mv  = low_code_mv(s_q.low_code);
  assign full_mv = chem_full_mv(s_q.chem);
  assign lookup  = chem_lookup(s_q.sh, s_q.ext);

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rdata = READ_ZERO;
    if (s_q.mirror) begin
      if (s_q.offs == OFF_PMODE) begin
        rdata = cable_powered ? PMODE_CABLE : PMODE_BATT;
      end else if (s_q.offs == OFF_CHG_STATE) begin
        rdata = chg_on_int ? CHG_ON : CHG_OFF;
      end
    end else begin
      if (s_q.offs == OFF_CHEM) begin
        rdata = chem_code(s_q.chem, s_q.ext);
      end else if (s_q.offs == OFF_CHG_CTRL) begin
        rdata = s_q.ctrl_auto ? CTRL_AUTO : CTRL_DISABLE;
      end else if (s_q.offs == OFF_LOW_THR) begin
        rdata = {4'h0, s_q.low_code};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d      = s_q;
    wr_fire  = 1'b0;
    s_d.scl_p = scl_i;
    s_d.sda_p = sda_i;

    // variant strap caught once, just after reset release
    if (!s_q.strap_done) begin
      s_d.ext        = board_ext;
      s_d.strap_done = 1'b1;
    end

    if (start_cond) begin
      s_d.st     = I_RX;
      s_d.kind   = K_ADDR;
      s_d.cnt    = 4'h0;
      s_d.sda_en = 1'b0;
    end else if (stop_cond) begin
      s_d.st     = I_IDLE;
      s_d.sda_en = 1'b0;
    end else begin
      case (s_q.st)
        I_RX: begin
          if (scl_rise && s_q.cnt < 4'h8) begin
            s_d.sh  = {s_q.sh[6:0], sda_i};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall && s_q.cnt == 4'h8) begin
            case (s_q.kind)
              K_ADDR: begin
                if (s_q.sh[7:1] == CMD_ADDR || s_q.sh[7:1] == MIRROR_ADDR) begin
                  s_d.mirror = (s_q.sh[7:1] == MIRROR_ADDR);
                  s_d.rd     = s_q.sh[0];
                  s_d.sda_en = 1'b1;
                  s_d.st     = I_ACK;
                end else begin
                  s_d.st = I_IDLE;
                end
              end
              K_OFFS: begin
                s_d.offs   = s_q.sh;
                s_d.sda_en = 1'b1;
                s_d.st     = I_ACK;
              end
              default: begin
                wr_fire    = 1'b1;
                s_d.offs   = s_q.offs + 8'h01;
                s_d.sda_en = 1'b1;
                s_d.st     = I_ACK;
              end
            endcase
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            s_d.cnt = 4'h0;
            if (s_q.rd && s_q.kind == K_ADDR) begin
              s_d.sh     = rdata;
              s_d.sda_en = ~rdata[7];
              s_d.cnt    = 4'h1;
              s_d.st     = I_TX;
            end else begin
              s_d.sda_en = 1'b0;
              s_d.kind   = (s_q.kind == K_ADDR) ? K_OFFS : K_DATA;
              s_d.st     = I_RX;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            if (s_q.cnt < 4'h8) begin
              s_d.sda_en = ~s_q.sh[6];
              s_d.sh     = {s_q.sh[6:0], 1'b0};
              s_d.cnt    = s_q.cnt + 4'h1;
            end else begin
              s_d.sda_en = 1'b0;
              s_d.offs   = s_q.offs + 8'h01;
              s_d.st     = I_RACK;
            end
          end
        end
        I_RACK: begin
          if (scl_rise && sda_i) begin
            s_d.st = I_IDLE;
          end else if (scl_fall) begin
            s_d.sh     = rdata;
            s_d.sda_en = ~rdata[7];
            s_d.cnt    = 4'h1;
            s_d.st     = I_TX;
          end
        end
        default: begin
          s_d.sda_en = 1'b0;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes, command space only; mirror space is read-only

    if (wr_fire && !s_q.mirror) begin
      if (s_q.offs == OFF_CHEM) begin
        // unknown codes leave chemistry and thresholds alone
        if (lookup[3]) begin
          s_d.chem     = chem_t'(lookup[2:0]);
          s_d.low_code = chem_low_code(chem_t'(lookup[2:0]));
        end
      end else if (s_q.offs == OFF_CHG_CTRL) begin
        if (cable_powered && s_q.sh <= CTRL_AUTO) begin
          s_d.ctrl_auto = s_q.sh[0];
        end
      end else if (s_q.offs == OFF_LOW_THR) begin
        if (s_q.sh <= LOW_CODE_MAX) begin
          s_d.low_code = s_q.sh[3:0];
        end
      end
    end

    // an update overrides a same-cycle host write of chemistry or low threshold
    if (fw_update) begin
      s_d.chem     = CHEM_RESET;
      s_d.low_code = chem_low_code(CHEM_RESET);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.st        <= I_IDLE;
      s_q.kind      <= K_ADDR;
      s_q.scl_p     <= 1'b1;
      s_q.sda_p     <= 1'b1;
      s_q.chem      <= CHEM_RESET;
      s_q.low_code  <= 4'h7;
      s_q.ctrl_auto <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_o  = s_q.sda_out;
  assign sda_oe = s_q.sda_en;

  ////////////////////////////////////////////////////////////////////////////
  // charger and warning logic

  charger_auto u_charger (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .ctrl_auto           (s_q.ctrl_auto),
    .cable_powered       (cable_powered),
    .batt_mv             (batt_mv),
    .full_mv             (full_mv),
    .current_flowing     (current_flowing),
    .charger_on          (chg_on_int),
    .charge_current_lamp (charge_current_lamp)
  );

  assign charger_on = chg_on_int;

  battery_warn #(
    .HOLD_CYC     (WARN_HOLD_CYCLES),
    .BEEP_PER_CYC (BEEP_PERIOD_CYCLES),
    .BEEP_ON_CYC  (BEEP_ON_CYCLES)
  ) u_warn (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .batt_mv      (batt_mv),
    .low_mv       (low_mv),
    .warn_lamp    (warn_lamp),
    .beeper       (beeper),
    .shutdown_req (shutdown_req)
  );

endmodule

// [verif/batt_cfg_monitor.sv]
// port-level assertion checker for the battery configuration register bank
`timescale 1ns/1ps
module batt_cfg_monitor
  import batt_cfg_pkg::*;
#(
  parameter int unsigned WARN_HOLD_CYCLES = 40
) (
  // clock and reset
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  // two-wire bus
  input wire logic                          scl_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe,
  // power and charger
  input wire logic                          cable_powered,
  input wire logic [batt_cfg_pkg::MV_W-1:0] batt_mv,
  input wire logic                          current_flowing,
  input wire logic                          charger_on,
  input wire logic                          charge_current_lamp,
  // low battery indication
  input wire logic                          warn_lamp,
  input wire logic                          beeper,
  input wire logic                          shutdown_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // length of the current unbroken warning run
  logic [31:0] warn_run_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_run_q <= 32'h0000_0000;
    end else begin
      warn_run_q <= warn_lamp ? warn_run_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////
  sequence beep_start_s;
    $rose(beeper);
  endsequence
  sequence warn_quiet_s;
    !warn_lamp [*2];
  endsequence

  a_sda_o_low: assert property (sda_o == 1'b0) else $error("data output not held low");
  a_sda_moves_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved with clock high");
  a_lamp_current: assert property (charge_current_lamp == ($past(charger_on) && $past(current_flowing)))
    else $error("charge lamp does not follow current flow");
  a_chg_on_cable: assert property (!$past(cable_powered) |-> !charger_on)
    else $error("charger on while on battery");
  a_chg_full_off: assert property ($past(batt_mv) >= FULL_MV_STD |-> !charger_on)
    else $error("charger on above full level");
  a_beep_with_warn: assert property (beeper |-> warn_lamp || $past(warn_lamp))
    else $error("beeper without warning");
  a_beep_short: assert property (beep_start_s |-> ##[3:5] !beeper)
    else $error("beep too long");
  a_shut_at_hold: assert property ($rose(shutdown_req) |-> warn_run_q + 32'h0000_0003 >= WARN_HOLD_CYCLES
    && warn_run_q <= WARN_HOLD_CYCLES + 3) else $error("shutdown at wrong warning time");
  a_shut_late: assert property (warn_run_q == WARN_HOLD_CYCLES + 4 |-> shutdown_req)
    else $error("shutdown missing after warning hold");
  a_shut_drops: assert property (warn_quiet_s |-> !shutdown_req)
    else $error("shutdown held without warning");
endmodule

// [verif/i2c_host_model.sv]
// two-wire bus controller model standing for the host processor
`timescale 1ns/1ps
module i2c_host_model (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // three cycles a phase, above the two the target needs
  localparam int PH = 3;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_ph();
    repeat (PH) @(posedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////
  // data only moves while the clock is low
  task automatic bit_io(input logic b, output logic s);
    wait_ph();
    sda_pull <= ~b;
    wait_ph();
    scl <= 1'b1;
    wait_ph();
    s = sda_line;
    scl <= 1'b0;
  endtask

  task automatic start();
    wait_ph();
    sda_pull <= 1'b0;
    wait_ph();
    scl <= 1'b1;
    wait_ph();
    sda_pull <= 1'b1;
    wait_ph();
    scl <= 1'b0;
  endtask

  task automatic stop();
    wait_ph();
    sda_pull <= 1'b1;
    wait_ph();
    scl <= 1'b1;
    wait_ph();
    sda_pull <= 1'b0;
  endtask

  // last high releases the line for the ninth bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({dev, 1'b0}, rx, a0);
    xfer(off, rx, a1);
    xfer(d, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // single byte read, ended by a not-acknowledge
  task automatic rd(input logic [6:0] dev, input logic [7:0] off, output logic [7:0] d);
    logic a;
    start();
    xfer({dev, 1'b0}, d, a);
    xfer(off, d, a);
    start();
    xfer({dev, 1'b1}, d, a);
    xfer(8'hFF, d, a);
    stop();
  endtask

  // two byte read: first byte acked so the target moves on to the next offset
  task automatic rd2(input logic [6:0] dev, input logic [7:0] off, output logic [15:0] d);
    logic a;
    start();
    xfer({dev, 1'b0}, d[7:0], a);
    xfer(off, d[7:0], a);
    start();
    xfer({dev, 1'b1}, d[7:0], a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i+8]);
    end
    bit_io(1'b0, a);
    xfer(8'hFF, d[7:0], a);
    stop();
  endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the battery configuration register bank
`timescale 1ns/1ps
bind battery_charge_config_regs batt_cfg_monitor #(.WARN_HOLD_CYCLES(WARN_HOLD_CYCLES)) mon (.sys_clk, .rst_n,
  .scl_i, .sda_o, .sda_oe, .cable_powered, .batt_mv, .current_flowing, .charger_on, .charge_current_lamp,
  .warn_lamp, .beeper, .shutdown_req);

module tb_top;
  import batt_cfg_pkg::*;
  localparam int unsigned HOLD = 40;
  localparam logic [7:0] CODES [10] = '{8'h53, 8'h46, 8'h49, 8'h48, 8'h4C, 8'h50, 8'h51, 8'h4F, 8'h4D, 8'h41};
  localparam logic [7:0] LOWS [5] = '{8'h07, 8'h01, 8'h06, 8'h04, 8'h03};
  logic            sys_clk;
  logic            rst_n;
  logic            board_ext;
  logic            cable_powered;
  logic            fw_update;
  logic [MV_W-1:0] batt_mv;
  logic            current_flowing;
  logic            scl;
  logic            sda_pull;
  logic            sda_o;
  logic            sda_oe;
  logic            sda_line;
  logic            charger_on;
  logic            charge_current_lamp;
  logic            warn_lamp;
  logic            beeper;
  logic            shutdown_req;
  logic            beep_seen;
  logic            ok;
  logic [7:0]      rv;
  logic [15:0]     rv2;
  int              fail_count;
  int              n_tests;

  // pulled-up wire, low when either party pulls
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

  battery_charge_config_regs #(.WARN_HOLD_CYCLES(HOLD), .BEEP_PERIOD_CYCLES(16), .BEEP_ON_CYCLES(4)) dut (
    .sys_clk, .rst_n, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .board_ext, .cable_powered, .fw_update,
    .batt_mv, .current_flowing, .charger_on, .charge_current_lamp, .warn_lamp, .beeper, .shutdown_req);
  i2c_host_model host (.sys_clk, .sda_line, .scl, .sda_pull);

  always #2 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d);
    host.wr(dev, off, d, ok);
    check("ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input string name, input logic [6:0] dev, input logic [7:0] off, input logic [7:0] exp);
    host.rd(dev, off, rv);
    check(name, rv, exp);
  endtask

  // ends on the default chemistry of the board
  task automatic chem_sweep(input int base);
    for (int i = 4; i >= 0; i--) begin
      wr(CMD_ADDR, OFF_CHEM, CODES[base+i]);
      rd_chk("chem", CMD_ADDR, OFF_CHEM, CODES[base+i]);
      rd_chk("low", CMD_ADDR, OFF_LOW_THR, LOWS[i]);
      check("chg_on", {7'h00, charger_on}, {7'h00, i != 1});
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    board_ext = 1'b0;
    cable_powered = 1'b1;
    fw_update = 1'b0;
    batt_mv = 13'h0E74;
    current_flowing = 1'b0;
    beep_seen = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk("ctrl", CMD_ADDR, OFF_CHG_CTRL, CTRL_AUTO);
    rd_chk("pmode", MIRROR_ADDR, OFF_PMODE, PMODE_CABLE);
    rd_chk("state", MIRROR_ADDR, OFF_CHG_STATE, CHG_ON);
    chem_sweep(0);
    wr(CMD_ADDR, OFF_CHEM, 8'h50);
    wr(CMD_ADDR, OFF_LOW_THR, 8'h09);
    rd_chk("chem", CMD_ADDR, OFF_CHEM, 8'h53);
    rd_chk("low", CMD_ADDR, OFF_LOW_THR, 8'h07);
    wr(CMD_ADDR, OFF_LOW_THR, 8'h08);
    rd_chk("low", CMD_ADDR, OFF_LOW_THR, 8'h08);
    wr(CMD_ADDR, OFF_LOW_THR, 8'h00);
    rd_chk("low", CMD_ADDR, OFF_LOW_THR, 8'h00);
    wr(MIRROR_ADDR, OFF_CHG_STATE, CHG_OFF);
    rd_chk("state", MIRROR_ADDR, OFF_CHG_STATE, CHG_ON);
    rd_chk("unmapped", CMD_ADDR, 8'h3F, READ_ZERO);
    host.wr(7'h55, OFF_CHEM, 8'h46, ok);
    check("nack", {7'h00, ok}, 8'h00);
    current_flowing <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("lamp", {7'h00, charge_current_lamp}, 8'h01);
    current_flowing <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("lamp", {7'h00, charge_current_lamp}, 8'h00);
    rd_chk("state", MIRROR_ADDR, OFF_CHG_STATE, CHG_ON);
    wr(CMD_ADDR, OFF_CHG_CTRL, CTRL_DISABLE);
    rd_chk("ctrl", CMD_ADDR, OFF_CHG_CTRL, CTRL_DISABLE);
    rd_chk("state", MIRROR_ADDR, OFF_CHG_STATE, CHG_OFF);
    cable_powered <= 1'b0;
    wr(CMD_ADDR, OFF_CHG_CTRL, CTRL_AUTO);
    rd_chk("ctrl", CMD_ADDR, OFF_CHG_CTRL, CTRL_DISABLE);
    rd_chk("pmode", MIRROR_ADDR, OFF_PMODE, PMODE_BATT);
    cable_powered <= 1'b1;
    wr(CMD_ADDR, OFF_CHG_CTRL, CTRL_AUTO);
    rd_chk("state", MIRROR_ADDR, OFF_CHG_STATE, CHG_ON);
    // 3.3V level, warning below 3.36V
    wr(CMD_ADDR, OFF_LOW_THR, 8'h05);
    // burst read walks from the control register into the low threshold
    host.rd2(CMD_ADDR, OFF_CHG_CTRL, rv2);
    check("burst_ctrl", rv2[15:8], CTRL_AUTO);
    check("burst_low", rv2[7:0], 8'h05);
    batt_mv <= 13'h0D20;
    repeat (10) @(posedge sys_clk);
    check("warn", {7'h00, warn_lamp}, 8'h00);
    batt_mv <= 13'h0D1F;
    for (int i = 0; i < HOLD + 4; i++) begin
      @(posedge sys_clk);
      beep_seen |= beeper;
      if (i == HOLD - 8) check("shut", {7'h00, shutdown_req}, 8'h00);
    end
    check("warn", {7'h00, warn_lamp}, 8'h01);
    check("beep", {7'h00, beep_seen}, 8'h01);
    check("shut", {7'h00, shutdown_req}, 8'h01);
    batt_mv <= 13'h0E74;
    repeat (4) @(posedge sys_clk);
    check("shut", {7'h00, shutdown_req}, 8'h00);
    // full battery stops charging
    batt_mv <= FULL_MV_STD;
    repeat (3) @(posedge sys_clk);
    check("chg_full", {7'h00, charger_on}, 8'h00);
    batt_mv <= 13'h0E74;
    wr(CMD_ADDR, OFF_CHEM, 8'h48);
    fw_update <= 1'b1;
    @(posedge sys_clk);
    fw_update <= 1'b0;
    rd_chk("chem", CMD_ADDR, OFF_CHEM, 8'h53);
    rd_chk("low", CMD_ADDR, OFF_LOW_THR, 8'h07);
    wr(CMD_ADDR, OFF_CHEM, 8'h48);
    rd_chk("low", CMD_ADDR, OFF_LOW_THR, 8'h04);
    // second reset, extended board strap
    rst_n <= 1'b0;
    board_ext <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk("chem", CMD_ADDR, OFF_CHEM, 8'h50);
    chem_sweep(5);
    wr(CMD_ADDR, OFF_CHEM, 8'h53);
    rd_chk("chem", CMD_ADDR, OFF_CHEM, 8'h50);
    stop_test();
  end
endmodule
